// ---- src/itpr_regs.svh ----
// Overview of operation
// - 3-bit priority per source, low nibble bits
// - nibble top bit unimplemented, reads zero
// - priority 0 lowest, 7 highest
// - equal priority ties broken by table position
// - natural order 0 highest, 53 lowest
// - interrupt number is tie-break rank
// - vector number is interrupt number plus eight
// - user level beats natural order
// - reset: pc zero, fetch at address zero
// - execute jump word, then go to target
// - four error conditions route to reset
// - watchdog expiry forces reset
// - unwritten pointer register use forces reset
// - illegal opcode resets only when executed
// - simultaneous traps force lockout reset
// - traps non-maskable, fixed priority
// - faulting instruction completes before trap, address error taken at once
// - traps levels 8-15, top level bit set
// - level 0111 blocks interrupts, not traps
// - invalid vector address raises address error
// - priority zero means source disabled
// - flag, enable, level above cpu level
// - nesting disable blocks new interrupt in service
`ifndef ITPR_REGS_SVH
`define ITPR_REGS_SVH

`define ITPR_ADDR_FLAG0     12'h000
`define ITPR_ADDR_FLAG1     12'h004
`define ITPR_ADDR_EN0       12'h008
`define ITPR_ADDR_EN1       12'h00c
`define ITPR_ADDR_PRIO0     12'h010
`define ITPR_ADDR_PRIO_LAST 12'h028
`define ITPR_ADDR_CTRL      12'h030
`define ITPR_ADDR_STATUS    12'h034

`define ITPR_CTRL_NSTD_BIT  0
`define ITPR_VEC_OFFSET     7'h08
`define ITPR_TRAP_LVL_BASE  4'h8
`define ITPR_LVL_BLOCK_ALL  4'h7
`define ITPR_ADDR_ERR_TRAP  3'h4
`define ITPR_RESET_PC       24'h000000
`define ITPR_JUMP_TGT_PC    24'h000002
`define ITPR_RESERVED_MASK  54'h3f_f81e_1780_8000

`endif

// ---- src/itpr_pkg.sv ----
package itpr_pkg;
    typedef enum logic [1:0] {
        ITPR_BOOT_JUMP,
        ITPR_BOOT_TARGET,
        ITPR_BOOT_LOAD,
        ITPR_RUN
    } itpr_boot_t;
endpackage

// ---- src/itpr_resolver.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "itpr_regs.svh"
module itpr_resolver #(
    parameter int           NUM_SRC      = 54,
    parameter logic [53:0]  RESERVED     = `ITPR_RESERVED_MASK
) (
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // peripheral events, one-cycle pulses on core_clk_i
    input  wire logic [NUM_SRC-1:0]  src_event_i,
    // core side
    input  wire logic [2:0]          cpu_priority_level_i,
    input  wire logic                cpu_level_top_bit_i,
    input  wire logic                irq_in_service_i,
    input  wire logic                vec_taken_i,
    input  wire logic                instr_done_i,
    input  wire logic [7:0]          trap_cond_i,
    input  wire logic                vec_addr_invalid_i,
    input  wire logic                wdt_expire_i,
    input  wire logic                uninit_ptr_use_i,
    input  wire logic                illegal_op_exec_i,
    input  wire logic [23:0]         prog_word_i,
    output logic                     vec_valid_o,
    output logic      [6:0]          vec_num_o,
    output logic      [3:0]          vec_level_o,
    output logic                     vec_is_trap_o,
    output logic                     error_reset_o,
    output logic      [3:0]          reset_cause_o,
    output logic                     boot_fetch_o,
    output logic      [23:0]         boot_addr_o,
    output logic                     start_valid_o,
    output logic      [23:0]         start_pc_o
);
    localparam int NPW = (NUM_SRC + 7) / 8;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: setup cycle latches answer, access cycle completes
    logic [NUM_SRC-1:0]  flag_q;
    logic [NUM_SRC-1:0]  en_q;
    logic [2:0]          prio_q [NUM_SRC];
    logic                nesting_disable_q;
    logic [7:0]          trap_pend_q;
    logic [63:0]         flag64;
    logic [63:0]         en64;
    logic [31:0]         rdata_d;
    logic                rerr_d;
    logic                setup;
    logic                wr_acc;
    logic [11:0]         prio_idx;
    logic [31:0]         status_word;
    logic                hit_flag0;
    logic                hit_flag1;
    logic                hit_en0;
    logic                hit_en1;
    logic                hit_prio;
    logic                hit_ctrl;

    assign setup    = psel_i & ~penable_i;
    assign wr_acc   = psel_i & penable_i & pwrite_i & pready_o;
    assign flag64   = {{(64 - NUM_SRC){1'b0}}, flag_q};
    assign en64     = {{(64 - NUM_SRC){1'b0}}, en_q};
    assign prio_idx = (paddr_i - `ITPR_ADDR_PRIO0) >> 2;
    assign hit_flag0 = paddr_i == `ITPR_ADDR_FLAG0;
    assign hit_flag1 = paddr_i == `ITPR_ADDR_FLAG1;
    assign hit_en0   = paddr_i == `ITPR_ADDR_EN0;
    assign hit_en1   = paddr_i == `ITPR_ADDR_EN1;
    assign hit_ctrl  = paddr_i == `ITPR_ADDR_CTRL;
    // an unaligned priority address is refused for writes as well as reads
    assign hit_prio  = paddr_i >= `ITPR_ADDR_PRIO0 && paddr_i <= `ITPR_ADDR_PRIO_LAST && paddr_i[1:0] == 2'b00;
    // status mirrors what the core is being shown right now
    assign status_word = {8'h00, trap_pend_q, 1'b0, vec_is_trap_o, vec_valid_o, 1'b0,
                          vec_level_o, 1'b0, vec_num_o};

    always_comb begin
        rdata_d = 32'h0000_0000;
        rerr_d  = 1'b0;
        case (paddr_i)
            `ITPR_ADDR_FLAG0:  rdata_d = flag64[31:0];
            `ITPR_ADDR_FLAG1:  rdata_d = flag64[63:32];
            `ITPR_ADDR_EN0:    rdata_d = en64[31:0];
            `ITPR_ADDR_EN1:    rdata_d = en64[63:32];
            `ITPR_ADDR_CTRL:   rdata_d[`ITPR_CTRL_NSTD_BIT] = nesting_disable_q;
            `ITPR_ADDR_STATUS: rdata_d = status_word;
            default: begin
                if (hit_prio) begin
                    for (int n = 0; n < 8; n++) begin
                        if (int'(prio_idx) * 8 + n < NUM_SRC) begin
                            rdata_d[n*4 +: 4] = {1'b0, prio_q[int'(prio_idx) * 8 + n]};
                        end
                    end
                end else begin
                    rerr_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            prdata_o  <= setup ? rdata_d : 32'h0000_0000;
            pslverr_o <= setup & rerr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags (write one to clear, a new event wins), enables, priorities
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            flag_q <= '0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (src_event_i[i] && !RESERVED[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (wr_acc && ((hit_flag0 && i < 32) || (hit_flag1 && i >= 32)) && pwdata_i[i % 32]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            en_q <= '0;
        end else if (wr_acc) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if ((hit_en0 && i < 32) || (hit_en1 && i >= 32)) begin
                    en_q[i] <= pwdata_i[i % 32];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_q[i] <= 3'h0;
            end
        end else if (wr_acc && hit_prio) begin
            for (int n = 0; n < 8; n++) begin
                if (int'(prio_idx) * 8 + n < NUM_SRC) begin
                    prio_q[int'(prio_idx) * 8 + n] <= pwdata_i[n*4 +: 3];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            nesting_disable_q <= 1'b0;
        end else if (wr_acc && hit_ctrl) begin
            nesting_disable_q <= pwdata_i[`ITPR_CTRL_NSTD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // traps: trap_cond_i captured only as the faulting instruction completes, address error at once
    logic [7:0] trap_new;
    logic [7:0] trap_ack;
    logic       multi_trap;

    always_comb begin
        trap_new = instr_done_i ? trap_cond_i : 8'h00;
        if (vec_addr_invalid_i) begin
            trap_new[`ITPR_ADDR_ERR_TRAP] = 1'b1;
        end
    end

    // two or more distinct traps arriving together cannot be ordered safely
    assign multi_trap = (trap_new & (trap_new - 8'h01)) != 8'h00;

    // only the trap on show can be acknowledged, and a new one of that level wins
    always_comb begin
        trap_ack = 8'h00;
        if (vec_taken_i && vec_is_trap_o && vec_level_o[3]) begin
            trap_ack[vec_level_o[2:0]] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            trap_pend_q <= 8'h00;
        end else begin
            for (int t = 0; t < 8; t++) begin
                if (trap_new[t]) begin
                    trap_pend_q[t] <= 1'b1;
                end else if (trap_ack[t]) begin
                    trap_pend_q[t] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error resets
    logic [3:0] cause_d;

    assign cause_d = {multi_trap, illegal_op_exec_i, uninit_ptr_use_i, wdt_expire_i};

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            error_reset_o <= 1'b0;
            reset_cause_o <= 4'h0;
        end else begin
            // a flushed illegal opcode never raises illegal_op_exec_i
            error_reset_o <= |cause_d;
            reset_cause_o <= cause_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // resolver: highest user level, lowest number on ties
    logic [NPW*8-1:0]    src_req;
    logic [NPW*24-1:0]   src_lvl;
    logic [NPW-1:0]      grp_ok;
    logic [3*NPW-1:0]    grp_lvl;
    logic [3*NPW-1:0]    grp_idx;
    logic [2:0]          best_grp;
    logic [2:0]          best_lvl;
    logic [5:0]          best_num;
    logic                best_ok;
    logic [2:0]          trap_idx;
    logic                trap_ok;
    logic [3:0]          cpu_lvl;
    logic                irq_go;

    // padding positions above the last source never request
    always_comb begin
        src_req = '0;
        src_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            src_req[i] = flag_q[i] && en_q[i] && !RESERVED[i] && prio_q[i] != 3'h0;
            src_lvl[i*3 +: 3] = prio_q[i];
        end
    end

    // groups of eight, then one pick across the NPW groups, keep the compare chain short at the cost of a mux
    for (genvar g = 0; g < NPW; g++) begin : g_grp
        itpr_group_pick #(
            .WIDTH (8)
        ) pick_u (
            .req_i (src_req[g*8 +: 8]),
            .lvl_i (src_lvl[g*24 +: 24]),
            .ok_o  (grp_ok[g]),
            .lvl_o (grp_lvl[g*3 +: 3]),
            .idx_o (grp_idx[g*3 +: 3])
        );
    end

    itpr_group_pick #(
        .WIDTH (NPW)
    ) final_u (
        .req_i (grp_ok),
        .lvl_i (grp_lvl),
        .ok_o  (best_ok),
        .lvl_o (best_lvl),
        .idx_o (best_grp)
    );

    // group number and place in the group together give the natural order number
    assign best_num = {best_grp, grp_idx[best_grp*3 +: 3]};

    always_comb begin
        trap_idx = 3'h0;
        trap_ok  = 1'b0;
        for (int t = 0; t < 8; t++) begin
            if (trap_pend_q[t]) begin
                trap_idx = 3'(t);
                trap_ok  = 1'b1;
            end
        end
    end

    // the top bit makes any trap level mask every interrupt
    assign cpu_lvl = {cpu_level_top_bit_i, cpu_priority_level_i};
    assign irq_go  = best_ok && {1'b0, best_lvl} > cpu_lvl &&
                     !(nesting_disable_q && irq_in_service_i);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            vec_valid_o   <= 1'b0;
            vec_num_o     <= 7'h00;
            vec_level_o   <= 4'h0;
            vec_is_trap_o <= 1'b0;
        end else if (trap_ok) begin
            vec_valid_o   <= 1'b1;
            vec_num_o     <= {4'h0, 3'h7 - trap_idx};
            vec_level_o   <= `ITPR_TRAP_LVL_BASE + {1'b0, trap_idx};
            vec_is_trap_o <= 1'b1;
        end else begin
            vec_valid_o   <= irq_go;
            vec_num_o     <= {1'b0, best_num} + `ITPR_VEC_OFFSET;
            vec_level_o   <= {1'b0, best_lvl};
            vec_is_trap_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start sequence: fetch word 0 (jump), word 2 (target), load pc
    itpr_pkg::itpr_boot_t boot_q;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            boot_q        <= itpr_pkg::ITPR_BOOT_JUMP;
            boot_fetch_o  <= 1'b0;
            boot_addr_o   <= `ITPR_RESET_PC;
            start_valid_o <= 1'b0;
            start_pc_o    <= `ITPR_RESET_PC;
        end else begin
            case (boot_q)
                itpr_pkg::ITPR_BOOT_JUMP: begin
                    boot_fetch_o <= 1'b1;
                    boot_addr_o  <= `ITPR_RESET_PC;
                    boot_q       <= itpr_pkg::ITPR_BOOT_TARGET;
                end
                itpr_pkg::ITPR_BOOT_TARGET: begin
                    boot_addr_o <= `ITPR_JUMP_TGT_PC;
                    boot_q      <= itpr_pkg::ITPR_BOOT_LOAD;
                end
                itpr_pkg::ITPR_BOOT_LOAD: begin
                    boot_fetch_o  <= 1'b0;
                    start_pc_o    <= prog_word_i;
                    start_valid_o <= 1'b1;
                    boot_q        <= itpr_pkg::ITPR_RUN;
                end
                itpr_pkg::ITPR_RUN: begin
                    start_valid_o <= 1'b0;
                end
                default: begin
                    boot_q <= itpr_pkg::ITPR_BOOT_JUMP;
                end
            endcase
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////
// one pick stage: highest level wins, lowest position on ties
module itpr_group_pick #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0]          req_i,
    input  wire logic [3*WIDTH-1:0]        lvl_i,
    output logic                           ok_o,
    output logic      [2:0]                lvl_o,
    output logic      [$clog2(WIDTH)-1:0]  idx_o
);
    localparam int IW = $clog2(WIDTH);

    always_comb begin
        ok_o  = 1'b0;
        lvl_o = 3'h0;
        idx_o = '0;
        // scanning downwards lets the lowest position overwrite its equals
        for (int n = WIDTH - 1; n >= 0; n--) begin
            if (req_i[n] && lvl_i[n*3 +: 3] >= lvl_o) begin
                ok_o  = 1'b1;
                lvl_o = lvl_i[n*3 +: 3];
                idx_o = IW'(n);
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/itpr_resolver_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module itpr_resolver_sva #(
    parameter int          NUM_SRC  = 54,
    parameter logic [53:0] RESERVED = '0
) (
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic [2:0] cpu_priority_level_i,
    input wire logic       cpu_level_top_bit_i,
    input wire logic       instr_done_i,
    input wire logic [7:0] trap_cond_i,
    input wire logic       wdt_expire_i,
    input wire logic       uninit_ptr_use_i,
    input wire logic       illegal_op_exec_i,
    input wire logic       vec_valid_o,
    input wire logic [6:0] vec_num_o,
    input wire logic [3:0] vec_level_o,
    input wire logic       vec_is_trap_o,
    input wire logic       error_reset_o,
    input wire logic [3:0] reset_cause_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////
    chk_trap_level: assert property (vec_valid_o && vec_is_trap_o |-> vec_level_o[3])
        else $error("trap shown below level 8");
    chk_trap_vector: assert property (vec_valid_o && vec_is_trap_o |-> vec_num_o == 7'h0f - {3'h0, vec_level_o})
        else $error("trap vector does not follow level");
    // the vector is registered, so it answers the cpu level of the cycle before
    chk_irq_above: assert property (vec_valid_o && !vec_is_trap_o |->
        vec_level_o > $past({cpu_level_top_bit_i, cpu_priority_level_i})) else $error("irq not above cpu level");
    chk_irq_vector: assert property (vec_valid_o && !vec_is_trap_o |->
        vec_num_o >= 7'h08 && !RESERVED[vec_num_o - 7'h08]) else $error("irq vector reserved or below 8");
    chk_wdt_reset: assert property (wdt_expire_i |=> error_reset_o && reset_cause_o[0])
        else $error("watchdog reset missing");
    chk_ptr_reset: assert property (uninit_ptr_use_i |=> error_reset_o && reset_cause_o[1])
        else $error("pointer reset missing");
    chk_opcode_reset: assert property (illegal_op_exec_i |=> error_reset_o && reset_cause_o[2])
        else $error("opcode reset missing");
    chk_trap_lockout: assert property (instr_done_i && $countones(trap_cond_i) > 1 |=>
        error_reset_o && reset_cause_o[3]) else $error("lockout reset missing");
endmodule
bind itpr_resolver itpr_resolver_sva #(.NUM_SRC(NUM_SRC), .RESERVED(RESERVED)) chk_u (.*);
`default_nettype wire

// ---- dv/itpr_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module itpr_core_model #(
    parameter logic [23:0] JUMP_WORD = 24'h040000, // arbitrary jump pattern
    parameter logic [23:0] START_PC  = 24'h000100
) (
    input  wire logic        core_clk_i,
    input  wire logic        boot_fetch_i,
    input  wire logic [23:0] boot_addr_i,
    input  wire logic        vec_valid_i,
    input  wire logic        take_en_i,
    input  wire logic [3:0]  dly_i,
    output logic      [23:0] prog_word_o,
    output logic             vec_taken_o
);
    logic [23:0] last_q;
    logic [3:0]  wait_q;
    ////////////////////////////////////////////////////////////
    // word 0 holds the jump, word 2 its target; an idle bus flips every cycle
    assign prog_word_o = !boot_fetch_i ? ~last_q : (boot_addr_i[1] ? START_PC : JUMP_WORD);
    always_ff @(posedge core_clk_i) begin
        last_q <= prog_word_o;
    end
    // dly_i sets how slowly the core takes a vector
    always_ff @(posedge core_clk_i) begin
        if (!take_en_i || !vec_valid_i) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hf) begin
            wait_q <= wait_q + 4'h1;
        end
    end
    assign vec_taken_o = take_en_i && vec_valid_i && wait_q == dly_i;
endmodule
`default_nettype wire

// ---- dv/interrupt_trap_priority_resolver_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "itpr_regs.svh"
module interrupt_trap_priority_resolver_tb;
    localparam logic [23:0] START = 24'h000120;
    logic        core_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_b, take_en;
    logic        cpu_level_top_bit_i, irq_in_service_i, vec_taken_i, instr_done_i, vec_addr_invalid_i;
    logic        wdt_expire_i, uninit_ptr_use_i, illegal_op_exec_i, vec_valid_o, vec_is_trap_o;
    logic        error_reset_o, boot_fetch_o, start_valid_o;
    logic [2:0]  cpu_priority_level_i;
    logic [3:0]  vec_level_o, reset_cause_o, dly;
    logic [6:0]  vec_num_o;
    logic [7:0]  trap_cond_i;
    logic [11:0] paddr_i;
    logic [23:0] prog_word_i, boot_addr_o, start_pc_o;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [53:0] src_event_i;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    ////////////////////////////////////////////////////////////
    itpr_resolver dut_u (.*);
    itpr_core_model #(.START_PC(START)) core_u (
        .core_clk_i  (core_clk_i),
        .boot_fetch_i(boot_fetch_o),
        .boot_addr_i (boot_addr_o),
        .vec_valid_i (vec_valid_o),
        .take_en_i   (take_en),
        .dly_i       (dly),
        .prog_word_o (prog_word_i),
        .vec_taken_o (vec_taken_i)
    );
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // the sequence needs fewer than a hundred cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // no wait-state count assumed; only the ceiling ends a hung wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err_b = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b1, `ITPR_ADDR_PRIO0, 32'hffff_ffff);
        apb(1'b1, 12'h011, 32'h0);
        chk("unaligned err", 32'h1, err_b);
        apb(1'b0, `ITPR_ADDR_PRIO0, 32'h0);
        chk("prio word", 32'h7777_7777, rd);
        apb(1'b0, 12'h03c, 32'h0);
        chk("unmapped err", 32'h1, err_b);
    endtask
    task automatic t_order();
        apb(1'b1, `ITPR_ADDR_EN0, 32'h0000_800b);
        apb(1'b1, `ITPR_ADDR_PRIO0, 32'h0000_5051);
        apb(1'b1, 12'h014, 32'h7000_0000);
        src_event_i <= 54'h800b;
        cyc(1);
        src_event_i <= '0;
        cyc(2);
        chk("irq vec", 32'h95, {vec_num_o, vec_level_o});
        apb(1'b0, `ITPR_ADDR_FLAG0, 32'h0);
        chk("flags", 32'h0000_000b, rd);
        apb(1'b1, `ITPR_ADDR_PRIO0, 32'h0000_5001);
        cyc(2);
        chk("irq vec", 32'hb5, {vec_num_o, vec_level_o});
        cpu_priority_level_i <= 3'h5;
        cyc(3);
        chk("vec valid", 32'h0, vec_valid_o);
    endtask
    task automatic t_trap();
        cpu_priority_level_i <= 3'h7;
        trap_cond_i <= 8'h08;
        cyc(3);
        chk("vec valid", 32'h0, vec_valid_o);
        instr_done_i <= 1'b1;
        cyc(1);
        instr_done_i <= 1'b0;
        trap_cond_i <= 8'h00;
        cyc(2);
        chk("trap vec", 32'h84b, {vec_is_trap_o, vec_num_o, vec_level_o});
        take_en <= 1'b1;
        cyc(4);
        chk("vec valid", 32'h0, vec_valid_o);
        dly <= 4'h3;
        vec_addr_invalid_i <= 1'b1;
        cyc(1);
        vec_addr_invalid_i <= 1'b0;
        cyc(2);
        chk("trap vec", 32'h83c, {vec_is_trap_o, vec_num_o, vec_level_o});
        cyc(6);
        chk("vec valid", 32'h0, vec_valid_o);
    endtask
    task automatic t_nest();
        cpu_priority_level_i <= 3'h0;
        cpu_level_top_bit_i <= 1'b1;
        apb(1'b1, `ITPR_ADDR_CTRL, 32'h1);
        chk("vec valid", 32'h0, vec_valid_o);
        cpu_level_top_bit_i <= 1'b0;
        irq_in_service_i <= 1'b1;
        cyc(3);
        chk("vec valid", 32'h0, vec_valid_o);
        irq_in_service_i <= 1'b0;
        cyc(3);
        chk("irq vec", 32'h8b, {vec_valid_o, vec_num_o});
    endtask
    // one row per reset cause: watchdog, pointer, opcode, lockout
    task automatic t_resets();
        for (int i = 0; i < 4; i++) begin
            wdt_expire_i <= (i == 0);
            uninit_ptr_use_i <= (i == 1);
            illegal_op_exec_i <= (i == 2);
            instr_done_i <= (i == 3);
            trap_cond_i <= (i == 3) ? 8'h03 : 8'h00;
            cyc(1);
            {wdt_expire_i, uninit_ptr_use_i, illegal_op_exec_i, instr_done_i} <= 4'h0;
            trap_cond_i <= 8'h00;
            cyc(1);
            chk("reset cause", 32'h10 | (32'h1 << i), {error_reset_o, reset_cause_o});
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, take_en, cpu_level_top_bit_i, irq_in_service_i} = '0;
        {instr_done_i, vec_addr_invalid_i, wdt_expire_i, uninit_ptr_use_i, illegal_op_exec_i} = '0;
        {cpu_priority_level_i, dly, trap_cond_i, paddr_i, pwdata_i, src_event_i} = '0;
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        cyc(4);
        chk("start pc", {8'h01, START}, {start_valid_o, start_pc_o});
        chk("boot bus", {8'h00, `ITPR_JUMP_TGT_PC}, {7'h00, boot_fetch_o, boot_addr_o});
        t_regs();
        t_order();
        t_trap();
        t_nest();
        t_resets();
        finish_test();
    end
endmodule
`default_nettype wire
